// ### hdl/pss_consts.svh
/*
 * Constants of the protective stop sequencer: register offsets, reset values
 * and timing counts. Assumes a 100 MHz ref_clk.
 */
// Functional notes
// [R1] Undervoltage trip select takes 0 or 1 and resets to 1.
// [R2] Select 0: power loss at servo-on drops to servo-off, no alarm.
// [R3] Select 0: servo-on returns by itself when main power comes back.
// [R4] Select 1: power loss at servo-on raises the undervoltage alarm.
// [R5] Detect time of 1000 makes the trip select have no effect.
// [R6] Bus undervoltage before power-loss detection always raises the alarm.
// [R7] Over-travel sequence takes 0 to 2, default 0, acts while an inhibit is on; the code acts only at servo-on.
// [R8] Sequence 0: dynamic brake, then zero torque toward inhibit; counter held.
// [R9] Sequence 1: zero torque while braking and after stop; counter held.
// [R10] Sequence 2: emergency stop, then zero torque; counter cleared throughout.
// [R11] Sequence 2: braking torque limited by the emergency-stop torque limit.
// [R12] Over-travel sequence values above 2 act as 0.
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH
`define PSS_ADDR_UV_SEL 8'h00
`define PSS_ADDR_OT_SEQ 8'h04
`define PSS_ADDR_POFF_TIME 8'h08
`define PSS_ADDR_ESTOP_TQ 8'h0C
`define PSS_ADDR_STATE 8'h10
`define PSS_ADDR_IRQ_STAT 8'h14
`define PSS_ADDR_IRQ_CLR 8'h18
`define PSS_ADDR_IRQ_EN 8'h1C
`define PSS_ADDR_CMD 8'h20
`define PSS_UV_SEL_RST 1'h1
`define PSS_OT_SEQ_RST 2'h0
`define PSS_POFF_TIME_RST 16'h0046
`define PSS_POFF_IGNORE 16'h03E8
`define PSS_ESTOP_TQ_RST 16'h0000
`define PSS_IRQ_W 4
`define PSS_IRQ_UV 0
`define PSS_IRQ_HOLD 1
`define PSS_IRQ_OT 2
`define PSS_IRQ_RESUME 3
`define PSS_CMD_ALM_RST 0
`define PSS_CLK_NS 10
`define PSS_MS_NS 1000000
`define PSS_MS_CYCLES (`PSS_MS_NS / `PSS_CLK_NS)
`endif

// ### hdl/pss_pkg.sv
/*
 * Types of the protective stop sequencer.
 * Assumes pss_consts.svh for all numeric values.
 */
package pss_pkg;
	typedef enum logic [1:0] {PS_OFF, PS_ON, PS_HOLD, PS_TRIP} pss_pwr_state_t;
	typedef enum logic [1:0] {OT_IDLE, OT_DECEL, OT_STOP} pss_ot_state_t;
	typedef enum logic [1:0] {OT_DB, OT_ZERO, OT_ESTOP} pss_ot_mode_t;
endpackage

// ### hdl/pss_ot_if.sv
/*
 * Carrier between the sequencer top and its over-travel stage.
 * Assumes both ends run on ref_clk.
 */
`timescale 1ns/1ps
interface pss_ot_if;
	import pss_pkg::*;
	pss_ot_mode_t mode;
	logic ccw;
	logic cw;
	logic stopped;
	logic servo_on;
	logic [15:0] estop_limit;
	logic dyn_brake;
	logic zt_ccw;
	logic zt_cw;
	logic estop_decel;
	logic [15:0] tq_limit;
	logic dev_clear;
	logic dev_hold;
	logic active;
	modport ctl (output mode, ccw, cw, stopped, servo_on, estop_limit,
		input dyn_brake, zt_ccw, zt_cw, estop_decel, tq_limit, dev_clear, dev_hold, active);
	modport seq (input mode, ccw, cw, stopped, servo_on, estop_limit,
		output dyn_brake, zt_ccw, zt_cw, estop_decel, tq_limit, dev_clear, dev_hold, active);
endinterface

// ### hdl/pss_ot_seq.sv
/*
 * Over-travel stop stage: braking, zero torque and deviation counter control
 * while a travel inhibit input is on at servo-on. Assumes synchronous inputs on ref_clk.
 */
`timescale 1ns/1ps
`include "pss_consts.svh"
module pss_ot_seq
	import pss_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// link to the top
	pss_ot_if.seq ot
);
	pss_ot_state_t state_reg, state_next;
	logic inhibit;
	logic dyn_brake_next, zt_ccw_next, zt_cw_next, estop_next, clr_next, hold_next;
	logic [15:0] tq_next;

	assign inhibit = (ot.ccw | ot.cw) & ot.servo_on;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			OT_IDLE: if (inhibit) state_next = OT_DECEL; // see [R7]
			OT_DECEL: begin
				if (!inhibit) state_next = OT_IDLE;
				else if (ot.stopped) state_next = OT_STOP;
			end
			OT_STOP: if (!inhibit) state_next = OT_IDLE;
			default: state_next = OT_IDLE;
		endcase
	end

	always_comb begin
		dyn_brake_next = 1'b0;
		zt_ccw_next = 1'b0;
		zt_cw_next = 1'b0;
		estop_next = 1'b0;
		clr_next = 1'b0;
		hold_next = 1'b0;
		tq_next = 16'hFFFF;
		if (state_next != OT_IDLE) begin
			case (ot.mode)
				OT_ZERO: begin
					zt_ccw_next = 1'b1; // see [R9]
					zt_cw_next = 1'b1;
					hold_next = 1'b1;
				end
				OT_ESTOP: begin
					clr_next = 1'b1; // see [R10]
					if (state_next == OT_DECEL) begin
						estop_next = 1'b1;
						tq_next = ot.estop_limit; // see [R11]
					end else begin
						zt_ccw_next = ot.ccw;
						zt_cw_next = ot.cw;
					end
				end
				default: begin
					hold_next = 1'b1; // see [R8]
					if (state_next == OT_DECEL) begin
						dyn_brake_next = 1'b1;
					end else begin
						zt_ccw_next = ot.ccw;
						zt_cw_next = ot.cw;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) state_reg <= OT_IDLE;
		else state_reg <= state_next;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ot.dyn_brake <= 1'b0;
			ot.zt_ccw <= 1'b0;
			ot.zt_cw <= 1'b0;
			ot.estop_decel <= 1'b0;
			ot.tq_limit <= 16'hFFFF;
			ot.dev_clear <= 1'b0;
			ot.dev_hold <= 1'b0;
			ot.active <= 1'b0;
		end else begin
			ot.dyn_brake <= dyn_brake_next;
			ot.zt_ccw <= zt_ccw_next;
			ot.zt_cw <= zt_cw_next;
			ot.estop_decel <= estop_next;
			ot.tq_limit <= tq_next;
			ot.dev_clear <= clr_next;
			ot.dev_hold <= hold_next;
			ot.active <= (state_next != OT_IDLE);
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence ot_start;
		state_reg == OT_IDLE && inhibit;
	endsequence
	sequence ot_braking;
		state_reg == OT_DECEL && ot.active;
	endsequence

	chk_ot_entry: assert property (ot_start |=> ot_braking) // see [R7]
		else $error("over-travel did not enter braking");
	chk_db_brake: assert property (state_reg == OT_DECEL && $past(ot.mode) == OT_DB
		|-> ot.dyn_brake && ot.dev_hold && !ot.dev_clear) // see [R8]
		else $error("sequence 0 braking wrong");
	chk_db_stop_dir: assert property (state_reg == OT_STOP && $past(ot.mode) == OT_DB
		|-> ot.zt_ccw == $past(ot.ccw) && ot.zt_cw == $past(ot.cw) && !ot.dyn_brake) // see [R8]
		else $error("sequence 0 stop torque wrong");
	chk_zero_both: assert property (state_reg != OT_IDLE && $past(ot.mode) == OT_ZERO
		|-> ot.zt_ccw && ot.zt_cw && ot.dev_hold) // see [R9]
		else $error("sequence 1 zero torque missing");
	chk_estop_clear: assert property (state_reg != OT_IDLE && $past(ot.mode) == OT_ESTOP
		|-> ot.dev_clear && !ot.dev_hold) // see [R10]
		else $error("sequence 2 counter not cleared");
	chk_estop_limit: assert property (state_reg == OT_DECEL && $past(ot.mode) == OT_ESTOP
		|-> ot.estop_decel && ot.tq_limit == $past(ot.estop_limit)) // see [R11]
		else $error("sequence 2 torque limit wrong");
endmodule

// ### hdl/pss_top.sv
/*
 * Protective stop sequencer top: register port, main power loss handling,
 * undervoltage alarm, servo enable, interrupts, and the over-travel stage.
 * Assumes all inputs synchronous to ref_clk (100 MHz).
 */
`timescale 1ns/1ps
`include "pss_consts.svh"
module pss_top
	import pss_pkg::*;
#(
	parameter int MS_CYCLES = `PSS_MS_CYCLES
)(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// power and motion inputs
	input wire logic main_power_ok,
	input wire logic bus_undervolt,
	input wire logic servo_on_req,
	input wire logic motor_stopped,
	// limit switches
	input wire logic ccw_travel_inhibit,
	input wire logic cw_travel_inhibit,
	// power stage commands
	output logic servo_enable,
	output logic dyn_brake,
	output logic zero_torque_ccw,
	output logic zero_torque_cw,
	output logic estop_decel,
	output logic [15:0] torque_limit,
	output logic dev_clear,
	output logic dev_hold,
	// alarm and interrupt
	output logic undervoltage_alarm,
	output logic irq
);
	logic undervoltage_trip_select_reg;
	logic [1:0] overtravel_sequence_select_reg;
	logic [15:0] power_off_detect_time_reg;
	logic [15:0] estop_torque_limit_reg;
	logic [`PSS_IRQ_W-1:0] irq_stat_reg, irq_en_reg, irq_evt, irq_clr;
	logic [31:0] rdata_next;
	logic alarm_reset;
	logic [31:0] ms_div_reg;
	logic [15:0] off_ms_reg;
	logic ms_tick, detect_on, detect;
	pss_pwr_state_t pwr_reg, pwr_next;
	logic ot_active_d_reg;
	pss_ot_if ot_bus ();

	// register writes
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			undervoltage_trip_select_reg <= `PSS_UV_SEL_RST; // see [R1]
			overtravel_sequence_select_reg <= `PSS_OT_SEQ_RST; // see [R7]
			power_off_detect_time_reg <= `PSS_POFF_TIME_RST;
			estop_torque_limit_reg <= `PSS_ESTOP_TQ_RST;
			irq_en_reg <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				`PSS_ADDR_UV_SEL: undervoltage_trip_select_reg <= reg_wdata[0];
				`PSS_ADDR_OT_SEQ: overtravel_sequence_select_reg <= reg_wdata[1:0];
				`PSS_ADDR_POFF_TIME: power_off_detect_time_reg <= reg_wdata[15:0];
				`PSS_ADDR_ESTOP_TQ: estop_torque_limit_reg <= reg_wdata[15:0];
				`PSS_ADDR_IRQ_EN: irq_en_reg <= reg_wdata[`PSS_IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	assign irq_clr = (reg_wr && reg_addr == `PSS_ADDR_IRQ_CLR) ?
		reg_wdata[`PSS_IRQ_W-1:0] : '0;
	assign alarm_reset = reg_wr && reg_addr == `PSS_ADDR_CMD && reg_wdata[`PSS_CMD_ALM_RST];

	// read mux, data valid only in the cycle after the strobe
	always_comb begin
		rdata_next = 32'h0000_0000;
		case (reg_addr)
			`PSS_ADDR_UV_SEL: rdata_next[0] = undervoltage_trip_select_reg;
			`PSS_ADDR_OT_SEQ: rdata_next[1:0] = overtravel_sequence_select_reg;
			`PSS_ADDR_POFF_TIME: rdata_next[15:0] = power_off_detect_time_reg;
			`PSS_ADDR_ESTOP_TQ: rdata_next[15:0] = estop_torque_limit_reg;
			`PSS_ADDR_STATE: rdata_next[3:0] = {ot_bus.active, detect, pwr_reg};
			`PSS_ADDR_IRQ_STAT: rdata_next[`PSS_IRQ_W-1:0] = irq_stat_reg;
			`PSS_ADDR_IRQ_EN: rdata_next[`PSS_IRQ_W-1:0] = irq_en_reg;
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) reg_rdata <= 32'h0000_0000;
		else if (reg_rd) reg_rdata <= rdata_next;
		else reg_rdata <= 32'h0000_0000;
	end

	// millisecond timing of a main power outage
	assign ms_tick = (ms_div_reg == 32'(MS_CYCLES - 1));

	always_ff @(posedge ref_clk) begin
		if (!rst_b || main_power_ok || ms_tick) ms_div_reg <= 32'h0000_0000;
		else ms_div_reg <= ms_div_reg + 32'h0000_0001;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b || main_power_ok) off_ms_reg <= 16'h0000;
		else if (ms_tick && off_ms_reg != 16'hFFFF) off_ms_reg <= off_ms_reg + 16'h0001;
	end

	// detection is off when the detect time holds the ignore value
	assign detect_on = (power_off_detect_time_reg != `PSS_POFF_IGNORE); // see [R5]
	assign detect = detect_on && !main_power_ok && (off_ms_reg >= power_off_detect_time_reg);

	// servo power state
	always_comb begin
		pwr_next = pwr_reg;
		case (pwr_reg)
			PS_OFF: if (servo_on_req && main_power_ok && !bus_undervolt) pwr_next = PS_ON;
			PS_ON: begin
				if (bus_undervolt) pwr_next = PS_TRIP; // see [R6]
				else if (detect && undervoltage_trip_select_reg) pwr_next = PS_TRIP; // see [R4]
				else if (detect) pwr_next = PS_HOLD; // see [R2]
				else if (!servo_on_req) pwr_next = PS_OFF;
			end
			PS_HOLD: begin
				if (main_power_ok && servo_on_req) pwr_next = PS_ON; // see [R3]
				else if (main_power_ok || !servo_on_req) pwr_next = PS_OFF;
			end
			PS_TRIP: if (alarm_reset && main_power_ok && !bus_undervolt) pwr_next = PS_OFF;
			default: pwr_next = PS_OFF;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) pwr_reg <= PS_OFF;
		else pwr_reg <= pwr_next;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			servo_enable <= 1'b0;
			undervoltage_alarm <= 1'b0;
		end else begin
			servo_enable <= (pwr_next == PS_ON);
			undervoltage_alarm <= (pwr_next == PS_TRIP);
		end
	end

	// over-travel stage
	assign ot_bus.mode = (overtravel_sequence_select_reg == 2'h1) ? OT_ZERO :
		(overtravel_sequence_select_reg == 2'h2) ? OT_ESTOP : OT_DB; // see [R12]
	assign ot_bus.ccw = ccw_travel_inhibit;
	assign ot_bus.cw = cw_travel_inhibit;
	assign ot_bus.stopped = motor_stopped;
	assign ot_bus.servo_on = servo_enable;
	assign ot_bus.estop_limit = estop_torque_limit_reg;

	pss_ot_seq u_ot (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.ot(ot_bus.seq)
	);

	assign dyn_brake = ot_bus.dyn_brake;
	assign zero_torque_ccw = ot_bus.zt_ccw;
	assign zero_torque_cw = ot_bus.zt_cw;
	assign estop_decel = ot_bus.estop_decel;
	assign torque_limit = ot_bus.tq_limit;
	assign dev_clear = ot_bus.dev_clear;
	assign dev_hold = ot_bus.dev_hold;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) ot_active_d_reg <= 1'b0;
		else ot_active_d_reg <= ot_bus.active;
	end

	// interrupt events, one cycle each
	assign irq_evt[`PSS_IRQ_UV] = (pwr_reg != PS_TRIP) && (pwr_next == PS_TRIP);
	assign irq_evt[`PSS_IRQ_HOLD] = (pwr_reg == PS_ON) && (pwr_next == PS_HOLD);
	assign irq_evt[`PSS_IRQ_OT] = ot_bus.active && !ot_active_d_reg;
	assign irq_evt[`PSS_IRQ_RESUME] = (pwr_reg == PS_HOLD) && (pwr_next == PS_ON);

	// sticky status, a new event wins over a clear in the same cycle
	genvar gi;
	generate
		for (gi = 0; gi < `PSS_IRQ_W; gi++) begin : g_irq
			always_ff @(posedge ref_clk) begin
				if (!rst_b) irq_stat_reg[gi] <= 1'b0;
				else if (irq_evt[gi]) irq_stat_reg[gi] <= 1'b1;
				else if (irq_clr[gi]) irq_stat_reg[gi] <= 1'b0;
			end
		end
	endgenerate

	assign irq = |(irq_stat_reg & irq_en_reg);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence power_lost_on;
		pwr_reg == PS_ON && !bus_undervolt && detect;
	endsequence
	sequence tripped;
		undervoltage_alarm && !servo_enable;
	endsequence

	chk_uv_sel_reset: assert property ($past(!rst_b) |-> undervoltage_trip_select_reg) // see [R1]
		else $error("trip select did not reset to one");
	chk_sel0_no_alarm: assert property (power_lost_on and !undervoltage_trip_select_reg
		|=> !undervoltage_alarm && !servo_enable && pwr_reg == PS_HOLD) // see [R2]
		else $error("select 0 power loss handled wrong");
	chk_auto_resume: assert property (pwr_reg == PS_HOLD && main_power_ok && servo_on_req
		|=> servo_enable && !undervoltage_alarm) // see [R3]
		else $error("servo-on did not resume");
	chk_sel1_trip: assert property (power_lost_on and undervoltage_trip_select_reg
		|=> tripped) // see [R4]
		else $error("select 1 power loss did not trip");
	chk_ignore_sel: assert property (power_off_detect_time_reg == `PSS_POFF_IGNORE
		&& pwr_reg == PS_ON && !bus_undervolt && servo_on_req |=> pwr_reg == PS_ON) // see [R5]
		else $error("detect time 1000 did not ignore selection");
	chk_bus_uv_trip: assert property (pwr_reg == PS_ON && bus_undervolt |=> tripped) // see [R6]
		else $error("bus undervoltage did not trip");
	chk_ot_fold: assert property (overtravel_sequence_select_reg == 2'h3
		|-> ot_bus.mode == OT_DB) // see [R12]
		else $error("out of range sequence not treated as 0");
	chk_irq_level: assert property (irq_evt[`PSS_IRQ_UV] && irq_en_reg[`PSS_IRQ_UV]
		|=> irq && irq_stat_reg[`PSS_IRQ_UV])
		else $error("undervoltage interrupt missing");

	sequence trip_kept;
		pwr_reg == PS_TRIP && !alarm_reset;
	endsequence

	// register port
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data not zero outside a read");
	chk_rdata_uv: assert property (reg_rd && reg_addr == `PSS_ADDR_UV_SEL // see [R1]
		|=> reg_rdata == {31'h0, $past(undervoltage_trip_select_reg)})
		else $error("trip select read back wrong");
	chk_rdata_ot: assert property (reg_rd && reg_addr == `PSS_ADDR_OT_SEQ // see [R7]
		|=> reg_rdata == {30'h0, $past(overtravel_sequence_select_reg)})
		else $error("over-travel sequence read back wrong");
	chk_uv_sel_field: assert property (reg_wr && reg_addr == `PSS_ADDR_UV_SEL // see [R1]
		|=> undervoltage_trip_select_reg == $past(reg_wdata[0]))
		else $error("trip select write wrong");
	chk_poff_field: assert property (reg_wr && reg_addr == `PSS_ADDR_POFF_TIME // see [R5]
		|=> power_off_detect_time_reg == $past(reg_wdata[15:0]))
		else $error("detect time write wrong");

	// power state
	chk_enable_state: assert property (servo_enable == (pwr_reg == PS_ON)) // see [R2]
		else $error("servo enable disagrees with power state");
	chk_alarm_state: assert property (undervoltage_alarm == (pwr_reg == PS_TRIP)) // see [R4]
		else $error("alarm disagrees with power state");
	chk_trip_latch: assert property (trip_kept |=> tripped) // see [R4]
		else $error("trip left without alarm reset");
	chk_hold_quiet: assert property (pwr_reg == PS_HOLD // see [R2]
		|-> !undervoltage_alarm && !servo_enable)
		else $error("temporary servo-off not quiet");
	chk_hold_wait: assert property (pwr_reg == PS_HOLD && !main_power_ok // see [R3]
		&& servo_on_req |=> pwr_reg == PS_HOLD)
		else $error("temporary servo-off left without main power");
	chk_ignore_detect: assert property (power_off_detect_time_reg == `PSS_POFF_IGNORE // see [R5]
		|-> !detect)
		else $error("detection active at the ignore value");
	chk_on_powered: assert property (pwr_reg == PS_ON && main_power_ok // see [R4]
		&& !bus_undervolt |=> !undervoltage_alarm)
		else $error("alarm raised with main power present");
	chk_off_refused: assert property (pwr_reg == PS_OFF && (!main_power_ok || bus_undervolt)
		|=> !servo_enable)
		else $error("servo-on granted without power");

	// interrupts
	chk_irq_set_wins: assert property (irq_evt[`PSS_IRQ_HOLD]
		|=> irq_stat_reg[`PSS_IRQ_HOLD])
		else $error("hold event lost");
	chk_irq_sticky: assert property (irq_stat_reg[`PSS_IRQ_OT] && !irq_clr[`PSS_IRQ_OT]
		|=> irq_stat_reg[`PSS_IRQ_OT])
		else $error("over-travel status not sticky");
	chk_irq_clear: assert property (irq_clr[`PSS_IRQ_UV] && !irq_evt[`PSS_IRQ_UV]
		|=> !irq_stat_reg[`PSS_IRQ_UV])
		else $error("undervoltage status not cleared");
	chk_irq_masked: assert property (irq_en_reg == '0 |-> !irq)
		else $error("interrupt raised while masked");
	chk_resume_event: assert property (pwr_reg == PS_HOLD && main_power_ok // see [R3]
		&& servo_on_req |=> irq_stat_reg[`PSS_IRQ_RESUME])
		else $error("resume event not recorded");

	// over-travel stage
	chk_ot_idle_limit: assert property (!ot_bus.active // see [R11]
		|-> torque_limit == 16'hFFFF)
		else $error("torque limited outside over-travel");
	chk_ot_needs_servo: assert property (!servo_enable && !ot_bus.active // see [R7]
		|=> !ot_bus.active)
		else $error("over-travel handled without servo-on");
endmodule

// ### tb/pss_stage_model.sv
/*
 * Behavioural power stage and limit switches of the protective stop sequencer.
 * Assumes the bench asks for inhibits by ccw_req and cw_req, on ref_clk.
 */
`timescale 1ns/1ps
module pss_stage_model #(
	parameter int STOP_DLY = 4
)(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// bench requests
	input wire logic ccw_req,
	input wire logic cw_req,
	// commands from the sequencer
	input wire logic dyn_brake,
	input wire logic estop_decel,
	input wire logic zero_torque_ccw,
	input wire logic zero_torque_cw,
	// switches and motion
	output logic ccw_travel_inhibit,
	output logic cw_travel_inhibit,
	output logic motor_stopped
);
	logic [3:0] run_cnt;

	assign ccw_travel_inhibit = ccw_req;
	assign cw_travel_inhibit = cw_req;

	// the motor coasts to zero speed some cycles after any braking command
	always_ff @(posedge ref_clk) begin
		if (!rst_b || !(ccw_req || cw_req)) begin
			run_cnt <= 4'h0;
			motor_stopped <= 1'b0;
		end else if (dyn_brake || estop_decel || (zero_torque_ccw && zero_torque_cw)) begin
			if (run_cnt == 4'(STOP_DLY - 1))
				motor_stopped <= 1'b1;
			else
				run_cnt <= run_cnt + 4'h1;
		end
	end
endmodule

// ### tb/pss_top_tb.sv
/*
 * Self-checking bench of the protective stop sequencer top.
 * Assumes the register map of pss_consts.svh and a 10-cycle millisecond.
 */
`timescale 1ns/1ps
`include "pss_consts.svh"
module pss_top_tb;
	logic ref_clk, rst_b, reg_wr, reg_rd, main_power_ok, bus_undervolt, servo_on_req;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic ccw_req, cw_req, motor_stopped, ccw_ti, cw_ti, servo_enable, dyn_brake;
	logic zt_ccw, zt_cw, estop_decel, dev_clear, dev_hold, undervoltage_alarm, irq;
	logic [15:0] torque_limit;
	logic [5:0] ot_out;
	assign ot_out = {dyn_brake, zt_ccw, zt_cw, estop_decel, dev_clear, dev_hold};
	int failures, n_compared, cyc, i, s;
	logic [5:0] dec_exp [4] = '{6'h21, 6'h19, 6'h06, 6'h21};
	logic [5:0] stop_exp [4] = '{6'h09, 6'h19, 6'h0A, 6'h11};

	pss_top #(.MS_CYCLES(10)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.main_power_ok(main_power_ok), .bus_undervolt(bus_undervolt),
		.servo_on_req(servo_on_req), .motor_stopped(motor_stopped),
		.ccw_travel_inhibit(ccw_ti), .cw_travel_inhibit(cw_ti), .servo_enable(servo_enable),
		.dyn_brake(dyn_brake), .zero_torque_ccw(zt_ccw), .zero_torque_cw(zt_cw),
		.estop_decel(estop_decel), .torque_limit(torque_limit), .dev_clear(dev_clear),
		.dev_hold(dev_hold), .undervoltage_alarm(undervoltage_alarm), .irq(irq));

	pss_stage_model #(.STOP_DLY(4)) stage (.ref_clk(ref_clk), .rst_b(rst_b), .ccw_req(ccw_req),
		.cw_req(cw_req), .dyn_brake(dyn_brake), .estop_decel(estop_decel),
		.zero_torque_ccw(zt_ccw), .zero_torque_cw(zt_cw), .ccw_travel_inhibit(ccw_ti),
		.cw_travel_inhibit(cw_ti), .motor_stopped(motor_stopped));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(name, reg_rdata, exp);
	endtask

	// waits up to 100 cycles for the servo enable to reach a level
	task automatic wait_en(input logic v);
		for (i = 0; i < 100 && servo_enable !== v; i++)
			@(posedge ref_clk);
		#1;
	endtask

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			close_out();
		end
	end

	initial begin
		rst_b = 1'b0;
		{reg_wr, reg_rd, bus_undervolt, servo_on_req, ccw_req, cw_req} = 6'h00;
		main_power_ok = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(`PSS_ADDR_UV_SEL, 32'h1, "uv_sel reset");
		rd(`PSS_ADDR_OT_SEQ, 32'h0, "ot_seq reset");
		rd(`PSS_ADDR_POFF_TIME, 32'h46, "poff reset");
		rd(8'h3C, 32'h0, "unmapped");
		wr(`PSS_ADDR_POFF_TIME, 32'h2);
		wr(`PSS_ADDR_IRQ_EN, 32'h1);
		// select 0: temporary servo-off, then automatic return
		wr(`PSS_ADDR_UV_SEL, 32'h0);
		servo_on_req <= 1'b1;
		wait_en(1'b1);
		chk("servo on", 32'(servo_enable), 32'h1);
		@(posedge ref_clk);
		main_power_ok <= 1'b0;
		wait_en(1'b0);
		chk("hold enable", 32'(servo_enable), 32'h0);
		chk("hold alarm", 32'(undervoltage_alarm), 32'h0);
		rd(`PSS_ADDR_STATE, 32'h6, "hold state");
		@(posedge ref_clk);
		main_power_ok <= 1'b1;
		wait_en(1'b1);
		chk("resume", 32'(servo_enable), 32'h1);
		rd(`PSS_ADDR_IRQ_STAT, 32'hA, "hold events");
		chk("irq masked", 32'(irq), 32'h0);
		wr(`PSS_ADDR_IRQ_CLR, 32'hF);
		// select 1: trip
		wr(`PSS_ADDR_UV_SEL, 32'hFFFFFFFF);
		rd(`PSS_ADDR_UV_SEL, 32'h1, "uv_sel field");
		@(posedge ref_clk);
		main_power_ok <= 1'b0;
		wait_en(1'b0);
		chk("trip alarm", 32'(undervoltage_alarm), 32'h1);
		chk("irq up", 32'(irq), 32'h1);
		@(posedge ref_clk);
		main_power_ok <= 1'b1;
		wr(`PSS_ADDR_IRQ_CLR, 32'h1);
		#1;
		chk("irq cleared", 32'(irq), 32'h0);
		wr(`PSS_ADDR_CMD, 32'h1);
		wait_en(1'b1);
		chk("alarm reset", 32'(undervoltage_alarm), 32'h0);
		// detection time 1000 disables the trip selection; run past 1000 ms of outage
		wr(`PSS_ADDR_POFF_TIME, 32'h3E8);
		main_power_ok <= 1'b0;
		repeat (10050) @(posedge ref_clk);
		#1;
		chk("no detect enable", 32'(servo_enable), 32'h1);
		chk("no detect alarm", 32'(undervoltage_alarm), 32'h0);
		rd(`PSS_ADDR_STATE, 32'h1, "no detect state");
		wr(`PSS_ADDR_UV_SEL, 32'h0);
		bus_undervolt <= 1'b1;
		wait_en(1'b0);
		chk("bus alarm", 32'(undervoltage_alarm), 32'h1);
		@(posedge ref_clk);
		bus_undervolt <= 1'b0;
		main_power_ok <= 1'b1;
		wr(`PSS_ADDR_CMD, 32'h1);
		wait_en(1'b1);
		// over-travel sequences, value 3 taken as 0 and driven from the ccw side
		wr(`PSS_ADDR_ESTOP_TQ, 32'h0123);
		for (s = 0; s < 4; s++) begin
			wr(`PSS_ADDR_OT_SEQ, 32'(s));
			@(posedge ref_clk);
			if (s == 3)
				ccw_req <= 1'b1;
			else
				cw_req <= 1'b1;
			@(posedge ref_clk);
			#1;
			chk("decel outputs", 32'(ot_out), 32'(dec_exp[s]));
			if (s == 2)
				chk("estop limit", 32'(torque_limit), 32'h0123);
			for (i = 0; i < 50 && motor_stopped !== 1'b1; i++)
				@(posedge ref_clk);
			repeat (2) @(posedge ref_clk);
			#1;
			chk("stop outputs", 32'(ot_out), 32'(stop_exp[s]));
			@(posedge ref_clk);
			ccw_req <= 1'b0;
			cw_req <= 1'b0;
			repeat (3) @(posedge ref_clk);
			#1;
			chk("idle outputs", 32'(ot_out), 32'h0);
			chk("idle limit", 32'(torque_limit), 32'hFFFF);
		end
		close_out();
	end
endmodule
